/* mnx_exec.v */
/*
  mnx_exec: executes the move-file, store-working, load-literal, idle and
  interrupt-return instructions of an 8-bit core. Instruction words are
  handed in through an APB register; working register, status, program
  counter, interrupt control, file registers and return stack are
  visible over the same bus.
  Assumes an APB master on pclk, synchronous inputs, and a master that
  keeps psel/penable/paddr/pwrite/pwdata stable through the access.
*/
// The register addresses and the APB slave port were chosen for this implementation.
`include "mnx_exec_consts.vh"

module mnx_exec #(
  parameter PC_W      = 13,
  parameter STACK_D   = 8,
  parameter FILE_D    = 128
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output reg         busy_q,
  output reg         global_irq_enable_q
);

  // ============================================================
  // State
  reg [7:0]      wreg_q;
  reg            zero_q;
  reg [PC_W-1:0] pc_q;
  reg [7:0]      intctl_lo_q;     // Bits 6..0 of interrupt control
  reg [6:0]      faddr_q;
  reg [2:0]      sp_q;
  reg [7:0]      file_mem [0:FILE_D-1];
  reg [PC_W-1:0] stack_mem [0:STACK_D-1];

  // Mask-and-match test shared by every opcode decode
  function is_op;
    input [`MNX_OP_W-1:0] word;
    input [`MNX_OP_W-1:0] mask;
    input [`MNX_OP_W-1:0] val;
    begin
      is_op = ((word & mask) == val);
    end
  endfunction

  // ============================================================
  // Bus phases
  wire            acc      = psel & penable;
  wire            done     = acc & pready;
  wire            wr_done  = done & pwrite;
  wire [13:0]     instr    = pwdata[13:0];
  wire [6:0]      fsel     = instr[`MNX_FADDR_MSB:0];
  wire [7:0]      fval     = file_mem[fsel];
  wire [PC_W-1:0] top      = stack_mem[sp_q - `MNX_SP_ONE];
  wire            mapped   = (paddr == `MNX_REG_INSTR)  |
                             (paddr == `MNX_REG_WREG)   |
                             (paddr == `MNX_REG_STATUS) |
                             (paddr == `MNX_REG_PC)     |
                             (paddr == `MNX_REG_INTCTL) |
                             (paddr == `MNX_REG_FADDR)  |
                             (paddr == `MNX_REG_FDATA)  |
                             (paddr == `MNX_REG_STACK)  |
                             (paddr == `MNX_REG_STKPTR);
  // An instruction is taken only when no two-cycle op is in flight
  wire            exec     = wr_done & (paddr == `MNX_REG_INSTR) & ~busy_q;

  wire op_mvfile = exec & is_op(instr, `MNX_MVFILE_MASK,
                                `MNX_MVFILE_VAL);
  wire op_stwork = exec & is_op(instr, `MNX_STWORK_MASK,
                                `MNX_STWORK_VAL);
  // Don't-care bits 9:8 are masked out of the decode
  wire op_ldlit  = exec & is_op(instr, `MNX_LDLIT_MASK,
                                `MNX_LDLIT_VAL);
  wire op_idle   = exec & is_op(instr, `MNX_IDLE_MASK, `MNX_IDLE_VAL);
  wire op_iret   = exec & is_op(instr, `MNX_IRET_MASK,
                                `MNX_IRET_VAL);
  wire dir_set   = instr[`MNX_DIR_BIT];

  // ============================================================
  // Read data mux, registered with the answer
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `MNX_REG_WREG:   rdata_d[7:0] = wreg_q;
      `MNX_REG_STATUS: begin
        rdata_d[`MNX_ST_BUSY_BIT] = busy_q;
        rdata_d[`MNX_ST_ZERO_BIT] = zero_q;
      end
      `MNX_REG_PC:     rdata_d[PC_W-1:0] = pc_q;
      `MNX_REG_INTCTL: rdata_d[7:0] = {global_irq_enable_q, intctl_lo_q[6:0]};
      `MNX_REG_FADDR:  rdata_d[6:0] = faddr_q;
      `MNX_REG_FDATA:  rdata_d[7:0] = file_mem[faddr_q];
      `MNX_REG_STACK:  rdata_d[PC_W-1:0] = top;
      `MNX_REG_STKPTR: rdata_d[2:0] = sp_q;
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // APB answer: one wait state, so every output comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (acc & ~pready) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= ~mapped;   // Unmapped address answers with an error
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ============================================================
  // Core registers: execution and software access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_q              <= `MNX_RST_BYTE;
      zero_q              <= 1'b0;
      pc_q                <= `MNX_PC_RST;
      intctl_lo_q         <= `MNX_RST_BYTE;
      global_irq_enable_q <= 1'b0;
      faddr_q             <= 7'h00;
      sp_q                <= 3'h0;
      busy_q              <= 1'b0;
    end else if (ce) begin
      // Second cycle of interrupt-return only retires the op
      if (busy_q) begin
        busy_q <= 1'b0;
      end
      if (op_mvfile & ~dir_set) begin
        wreg_q <= fval;
      end
      if (op_mvfile) begin
        zero_q <= (fval == `MNX_RST_BYTE);
        pc_q   <= pc_q + `MNX_PC_ONE;
      end
      if (op_stwork) begin
        pc_q <= pc_q + `MNX_PC_ONE;
      end
      if (op_ldlit) begin
        wreg_q <= instr[`MNX_LIT_MSB:0];
        pc_q   <= pc_q + `MNX_PC_ONE;
      end
      if (op_idle) begin
        pc_q <= pc_q + `MNX_PC_ONE;
      end
      if (op_iret) begin
        pc_q                <= top;
        sp_q                <= sp_q - `MNX_SP_ONE;
        global_irq_enable_q <= 1'b1;
        busy_q              <= 1'b1;
      end
      // Unrecognised words fall through as idle and advance the counter
      if (exec & ~(op_mvfile | op_stwork | op_ldlit | op_iret | op_idle)) begin
        pc_q <= pc_q + `MNX_PC_ONE;
      end
      // Software side; cannot collide with exec in the same transfer
      if (wr_done) begin
        case (paddr)
          `MNX_REG_WREG:   wreg_q <= pwdata[7:0];
          `MNX_REG_STATUS: zero_q <= pwdata[`MNX_ST_ZERO_BIT];
          `MNX_REG_INTCTL: begin
            global_irq_enable_q <= pwdata[`MNX_IRQEN_BIT];
            intctl_lo_q         <= {1'b0, pwdata[6:0]};
          end
          `MNX_REG_FADDR:  faddr_q <= pwdata[6:0];
          // Push wraps silently; depth overflow loses the oldest entry
          `MNX_REG_STACK:  sp_q <= sp_q + `MNX_SP_ONE;
          default:         ;
        endcase
      end
    end
  end

  // ============================================================
  // File registers and return stack storage (no reset, like RAM)
  always @(posedge pclk) begin
    if (ce) begin
      if (op_mvfile & dir_set) begin
        file_mem[fsel] <= fval;
      end
      if (op_stwork) begin
        file_mem[fsel] <= wreg_q;
      end
      if (wr_done & (paddr == `MNX_REG_FDATA)) begin
        file_mem[faddr_q] <= pwdata[7:0];
      end
      if (wr_done & (paddr == `MNX_REG_STACK)) begin
        stack_mem[sp_q] <= pwdata[PC_W-1:0];
      end
    end
  end

endmodule // mnx_exec

/* mnx_exec_consts.vh */
/*
  Constants for the mnx_exec instruction execution block: instruction
  encodings, register offsets, field positions and reset values.
  Assumes it is included once by mnx_exec.v and holds definitions only.
*/
// What this block does
// - Move-file reads the file register at 7-bit address 0..127; instruction bit 7 is its direction bit.
// - Direction clear: fetched value goes to working register, file unchanged.
// - Direction set: fetched value is written back into the same file register.
// - Move-file sets zero flag from moved value; other flags stay untouched.
// - Store-working copies working register into file 0..127, one cycle, no flags.
// - Load-literal puts 8-bit immediate into working register, no flag change.
// - Load-literal don't-care bits come as zeros and the decoder ignores them.
// - Interrupt-return pops the return stack into the program counter, no flags.
// - Interrupt-return sets global interrupt enable, bit 7 of interrupt control.
`ifndef MNX_EXEC_CONSTS_VH
`define MNX_EXEC_CONSTS_VH

// ============================================================
// Instruction encodings (14-bit word, mask and match value)
`define MNX_OP_W          14
`define MNX_MVFILE_MASK   14'h3f00
`define MNX_MVFILE_VAL    14'h0800
`define MNX_STWORK_MASK   14'h3f80
`define MNX_STWORK_VAL    14'h0080
`define MNX_LDLIT_MASK    14'h3c00
`define MNX_LDLIT_VAL     14'h3000
`define MNX_IDLE_MASK     14'h3f9f
`define MNX_IDLE_VAL      14'h0000
`define MNX_IRET_MASK     14'h3fff
`define MNX_IRET_VAL      14'h0009
`define MNX_DIR_BIT       7
`define MNX_FADDR_MSB     6
`define MNX_LIT_MSB       7

// ============================================================
// APB register byte offsets
`define MNX_REG_INSTR     8'h00
`define MNX_REG_WREG      8'h04
`define MNX_REG_STATUS    8'h08
`define MNX_REG_PC        8'h0c
`define MNX_REG_INTCTL    8'h10
`define MNX_REG_FADDR     8'h14
`define MNX_REG_FDATA     8'h18
`define MNX_REG_STACK     8'h1c
`define MNX_REG_STKPTR    8'h20

// ============================================================
// Field positions and reset values
`define MNX_ST_BUSY_BIT   0
`define MNX_ST_ZERO_BIT   2
`define MNX_IRQEN_BIT     7
`define MNX_RST_BYTE      8'h00
`define MNX_PC_RST        13'h0000
`define MNX_PC_ONE        13'h0001
`define MNX_SP_ONE        3'h1

`endif

/* mnx_exec_properties.sv */
/*
  Port checker for mnx_exec, bound into every instance.
  Assumes one clock pclk and the active-low reset presetn.
*/
module mnx_exec_chk (
  input wire logic        pclk, presetn, ce, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr, busy_q, global_irq_enable_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Completing write of an interrupt-return word
  wire ret_w = psel && penable && pready && pwrite && paddr == 8'h00
    && pwdata[13:0] == 14'h0009 && !busy_q;
  wire irq_en_w = psel && penable && pready && pwrite && paddr == 8'h10
    && pwdata[7];
  sequence s_ret_wr; ret_w; endsequence
  sequence s_busy_two; busy_q ##1 !busy_q; endsequence
  // Bus answer comes after exactly one wait state
  a_one_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("bus answer late");
  a_ready_pulse: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  a_bad_addr: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 0)
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_good_addr: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 0
    |-> !pslverr) else $error("mapped access refused");
  a_instr_rd_zero: assert property (pready && !pwrite && paddr == 8'h00
    |-> prdata == 32'h0) else $error("instruction slot read nonzero");
  // Return sets the enable and holds off for one extra cycle
  a_ret_irq_set: assert property (s_ret_wr |=> global_irq_enable_q)
    else $error("return left interrupts off");
  a_ret_two_cyc: assert property (s_ret_wr |=> s_busy_two)
    else $error("return not two cycles");
  a_busy_cause: assert property ($rose(busy_q) |-> $past(ret_w))
    else $error("busy without return");
  a_irq_en_cause: assert property ($rose(global_irq_enable_q)
    |-> $past(ret_w) || $past(irq_en_w)) else $error("enable rose alone");
endmodule // mnx_exec_chk

bind mnx_exec mnx_exec_chk u_chk (.*);

/* mnx_pmem.sv */
/*
  Program memory model: hands the bench one instruction word per index.
  Assumes the bench settles the index a clock before using the word.
*/
module mnx_pmem (
  input  wire logic [2:0]  pm_addr,
  output logic      [13:0] pm_word
);
  timeunit 1ns; timeprecision 1ns;
  // Don't-care bits of the literal load are emitted as zeros
  always_comb begin
    case (pm_addr)
      3'h0: pm_word = {4'hc, 2'b00, 8'h5a};
      3'h1: pm_word = 14'h00ff;   // Store working to file 7f
      3'h2: pm_word = 14'h087f;   // Move file 7f to working
      3'h3: pm_word = 14'h0880;   // Move file 00 onto itself
      3'h4: pm_word = 14'h0000;   // Idle
      default: pm_word = 14'h0009; // Interrupt return
    endcase
  end
endmodule // mnx_pmem

/* tb_mnx_exec.sv */
/*
  Self-checking bench for mnx_exec: drives APB, fetches words from
  the program memory model. Assumes a 10 MHz pclk.
*/
module tb_mnx_exec;
  timeunit 1ns; timeprecision 1ns;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, busy_q;
  logic irq_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pm_addr;
  logic [13:0] pm_word;
  int err_total, check_count;
  mnx_exec DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy_q(busy_q),
    .global_irq_enable_q(irq_en));
  mnx_pmem u_pm (.pm_addr(pm_addr), .pm_word(pm_word));
  // ==========================================================
  // Tasks
  task automatic complete_run;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait so a dead slave ends the run instead of hanging
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; complete_run(); end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r; logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic ex(input logic [2:0] i);
    pm_addr <= i;
    @(posedge pclk);
    wr(8'h00, {18'h0, pm_word});
  endtask
  // ==========================================================
  // Clock, reset and main sequence
  initial begin pclk = 0; forever #50 pclk = ~pclk; end
  initial begin
    logic [31:0] r; logic e;
    {presetn, psel, penable, pwrite, paddr, pwdata, pm_addr} = '0;
    ce = 1; err_total = 0; check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(8'h04, 0); rd(8'h08, 0); rd(8'h0c, 0); rd(8'h10, 0);
    ex(0); rd(8'h04, 32'h5a); rd(8'h0c, 1);
    wr(8'h08, 32'h4); ex(1); rd(8'h08, 32'h4);
    wr(8'h14, 32'h7f); rd(8'h18, 32'h5a);
    wr(8'h00, 32'h3300); rd(8'h04, 0); rd(8'h08, 32'h4);
    ex(2); rd(8'h04, 32'h5a); rd(8'h08, 0);
    rd(8'h0c, 4); rd(8'h18, 32'h5a);
    wr(8'h14, 0); wr(8'h18, 0); ex(3); rd(8'h08, 32'h4);
    rd(8'h04, 32'h5a); rd(8'h18, 0);
    ex(4); rd(8'h0c, 6); rd(8'h08, 32'h4); rd(8'h04, 32'h5a);
    wr(8'h1c, 32'h1abc); rd(8'h20, 1); wr(8'h10, 32'h7f);
    ex(5); rd(8'h0c, 32'h1abc); rd(8'h20, 0);
    rd(8'h10, 32'hff); rd(8'h08, 32'h4);
    // Unmapped place is refused; only the pslverr bit is checked
    apb(8'h24, 1'b0, 32'h0, r, e);
    chk({31'h0, e}, 1);
    complete_run();
  end
endmodule // tb_mnx_exec
